// [ebx_pkg.sv]
// constants, types and helpers shared by the external bus master
package ebx_pkg;

    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int MAX_XFERS = 16;
    localparam int CNT_W = 5;

    // size encodings, shared by operand size, port size and the size lines
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LINE = 2'h3;

    localparam logic ATM_CODE = 1'b1;
    localparam logic ATM_DATA = 1'b0;
    localparam logic ATM_SUPER = 1'b1;
    localparam logic ATM_USER = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    localparam logic [1:0] TT_RESET = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_WAIT = 4'h4,
        ST_HOLD = 4'h8
    } ebx_state_type;

    // bytes carried by a size code
    function automatic logic [CNT_W-1:0] ebx_bytes(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: ebx_bytes = 5'h01;
            SZ_WORD: ebx_bytes = 5'h02;
            SZ_LONG: ebx_bytes = 5'h04;
            default: ebx_bytes = 5'h10;
        endcase
    endfunction : ebx_bytes

    // size lines: the port size when the operand is wider, else the operand size
    function automatic logic [1:0] ebx_xfer_size(input logic [1:0] op, input logic [1:0] port);
        ebx_xfer_size = (ebx_bytes(op) > ebx_bytes(port)) ? port : op;
    endfunction : ebx_xfer_size

    // number of port-sized transfers needed for one operand
    function automatic logic [CNT_W-1:0] ebx_xfer_count(input logic [1:0] op, input logic [1:0] port);
        ebx_xfer_count = (ebx_bytes(op) > ebx_bytes(port)) ? (ebx_bytes(op) / ebx_bytes(port)) : CNT_ONE;
    endfunction : ebx_xfer_count

endpackage : ebx_pkg

// [ebx_stream_if.sv]
// valid/ready word stream between the master and its write-data buffer
`timescale 1ns/1ps
interface ebx_stream_if #(
    parameter int WIDTH = 32
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ebx_stream_if

// [ebx_fifo.sv]
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/1ps
module ebx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic srst_in,
    ebx_stream_if.snk fill,
    ebx_stream_if.src drain
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;
    assign fill.ready = (count_r != (PW+1)'(DEPTH));
    assign drain.valid = (count_r != '0);
    assign drain.data = mem[rd_ptr_r];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= fill.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            case ({push, pop})
                2'b10: count_r <= count_r + 1'b1;
                2'b01: count_r <= count_r - 1'b1;
                default: count_r <= count_r;
            endcase
        end
    end
endmodule : ebx_fifo

// [ebx_master.sv]
// external bus master: burst-inhibited writes and acknowledge termination
// Function
// R1: split a wide inhibited write into 2 to 16 port-sized transfers
// R2: first cycle drives address, type, mode, write direction and start strobe
// R3: size lines show 2 for word, 1 for byte, port size when split
// R4: second cycle negates start, shows privilege, drives data through waits
// R5: sample synchronous ack each rising edge from cycle two; else wait
// R6: a 16-bit slave captures the upper data half on its ack
// R7: between transfers step low address, restart strobe, show code or data
// R8: after the final acknowledged transfer release data drivers next cycle
// R9: async ack ends any transfer except to DRAM
// R10: async ack passes a synchroniser; only the inner version ends transfers
// R11: error ack during async synchronisation ends the transfer in error
// R12: slave holds read data 1.5 cycles after its async ack
// R13: write data stays driven until the inner async ack falling edge
// R14: async ack before cycle-two falling edge completes at end of cycle three
// R15: 8-bit async byte read captures the top byte lane on inner ack
// R16: slave holds async ack negated to add wait states
// R17: zero-wait async termination needs ack asserted before start, tied low
// R18: slave may latch write data in cycle two or end of cycle three
// R19: reads drive direction high; mode line shows code/data then privilege
// R20: inhibited mode when burst enable clear and operand wider than port; code splits every wide operand, ignoring burst enable
// R21: async ack synchroniser has two falling-edge stages
`timescale 1ns/1ps
module ebx_master #(
    parameter int FIFO_WORDS = ebx_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [ebx_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_op_size_in,
    input wire logic [1:0] req_port_size_in,
    input wire logic req_burst_en_in,
    input wire logic req_dram_in,
    input wire logic [1:0] req_xfer_type_in,
    input wire logic req_super_in,
    input wire logic req_code_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [ebx_pkg::DATA_W-1:0] wr_data_in,
    output logic rd_valid_out,
    output logic [ebx_pkg::DATA_W-1:0] rd_data_out,
    output logic done_out,
    output logic err_out,
    output logic [ebx_pkg::ADDR_W-1:0] addr_out,
    output logic rw_out,
    output logic [1:0] xfer_type_out,
    output logic [1:0] xfer_size_out,
    output logic access_mode_line_out,
    output logic xfer_start_n_out,
    output logic [ebx_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    input wire logic [ebx_pkg::DATA_W-1:0] data_in,
    input wire logic sync_xfer_ack_n_in,
    input wire logic async_xfer_ack_n_in,
    input wire logic xfer_error_ack_n_in
);
    import ebx_pkg::*;

    ebx_stream_if #(.WIDTH(DATA_W)) fill_if ();
    ebx_stream_if #(.WIDTH(DATA_W)) drain_if ();

    ebx_state_type state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [CNT_W-1:0] left_r;
    logic wr_r;
    logic dram_r;
    logic super_r;
    logic code_r;
    logic [1:0] port_r;
    logic [1:0] op_r;
    logic ata_s1_r;
    logic ata_s2_r;
    logic req_ready_r;
    logic take;
    logic ack_sync;
    logic ack_async;
    logic err_now;
    logic done_now;
    logic more;
    logic go_start;

    assign fill_if.valid = wr_valid_in;
    assign fill_if.data = wr_data_in;
    assign wr_ready_out = fill_if.ready;
    assign drain_if.ready = (state_r == ST_START) && wr_r;

    ebx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_WORDS)) u_wr_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .fill(fill_if),
        .drain(drain_if)
    );

    // two falling-edge stages resolve metastability before the rising sample
    always_ff @(negedge clk_in) begin
        if (srst_in) begin
            ata_s1_r <= 1'b0;
            ata_s2_r <= 1'b0;
        end else begin
            ata_s1_r <= !async_xfer_ack_n_in; // see R10 see R21
            ata_s2_r <= ata_s1_r; // see R14 see R21
        end
    end

    assign take = (state_r == ST_IDLE) && req_ready_r && req_valid_in && (!req_write_in || drain_if.valid);
    assign ack_sync = !sync_xfer_ack_n_in; // see R5
    assign ack_async = ata_s2_r && !dram_r; // see R9 see R10
    assign err_now = !xfer_error_ack_n_in; // see R11
    assign done_now = (state_r == ST_WAIT) && (err_now || ack_sync || ack_async);
    assign more = left_r != CNT_ONE;
    assign go_start = take
        || (done_now && !err_now && more && (!wr_r || drain_if.valid))
        || ((state_r == ST_HOLD) && drain_if.valid);

    // sequencing and operand bookkeeping
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
            req_ready_r <= 1'b0;
            left_r <= CNT_ONE;
            addr_r <= '0;
            wr_r <= 1'b0;
            dram_r <= 1'b0;
            super_r <= 1'b0;
            code_r <= 1'b0;
            port_r <= SZ_LONG;
            op_r <= SZ_LONG;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    req_ready_r <= !take;
                    if (take) begin
                        state_r <= ST_START;
                        addr_r <= req_addr_in;
                        wr_r <= req_write_in;
                        dram_r <= req_dram_in;
                        super_r <= req_super_in;
                        code_r <= req_code_in;
                        port_r <= req_port_size_in;
                        op_r <= req_op_size_in;
                        // bursting is not built, so every wide operand is split
                        left_r <= ebx_xfer_count(req_op_size_in, req_port_size_in); // see R1 see R20
                    end
                end
                ST_START: begin
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (done_now) begin
                        if (err_now || !more) begin
                            state_r <= ST_IDLE;
                            req_ready_r <= 1'b1;
                        end else begin
                            state_r <= go_start ? ST_START : ST_HOLD; // see R1
                            left_r <= left_r - CNT_ONE;
                            addr_r <= addr_r + {{(ADDR_W-CNT_W){1'b0}}, ebx_bytes(port_r)}; // see R7
                        end
                    end
                end
                ST_HOLD: begin
                    if (go_start) begin
                        state_r <= ST_START;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    req_ready_r <= 1'b1;
                end
            endcase
        end
    end

    assign req_ready_out = req_ready_r;
    assign addr_out = addr_r; // see R2 see R7

    // transfer attribute and strobe pins
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rw_out <= RW_READ;
            xfer_type_out <= TT_RESET;
            xfer_size_out <= SZ_LONG;
            access_mode_line_out <= ATM_DATA;
            xfer_start_n_out <= 1'b1;
        end else begin
            if (take) begin
                rw_out <= req_write_in ? RW_WRITE : RW_READ; // see R2 see R19
                xfer_type_out <= req_xfer_type_in; // see R2
                xfer_size_out <= ebx_xfer_size(req_op_size_in, req_port_size_in); // see R3
            end
            if (go_start) begin
                xfer_start_n_out <= 1'b0; // see R2 see R7
                access_mode_line_out <= (take ? req_code_in : code_r) ? ATM_CODE : ATM_DATA; // see R7 see R19
            end else if (state_r == ST_START) begin
                xfer_start_n_out <= 1'b1; // see R4
                access_mode_line_out <= super_r ? ATM_SUPER : ATM_USER; // see R4 see R19
            end
        end
    end

    // write data drivers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            data_out <= '0;
            data_oe_n_out <= 1'b1;
        end else begin
            if ((state_r == ST_START) && wr_r) begin
                data_out <= drain_if.data; // see R4
                data_oe_n_out <= 1'b0; // see R4 see R13
            end else if (done_now && (err_now || !more)) begin
                data_oe_n_out <= 1'b1; // see R8
            end
        end
    end

    // read capture and completion report
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            done_out <= 1'b0;
            err_out <= 1'b0;
        end else begin
            rd_valid_out <= done_now && !err_now && !wr_r;
            done_out <= done_now && !err_now && !more;
            err_out <= done_now && err_now; // see R11
            if (done_now && !err_now && !wr_r) begin
                case (port_r)
                    SZ_BYTE: rd_data_out <= {24'h000000, data_in[31:24]}; // see R15
                    SZ_WORD: rd_data_out <= {16'h0000, data_in[31:16]};
                    default: rd_data_out <= data_in;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // strobe cycle with the async ack not yet seen at any falling edge
    sequence s_async_c1;
        (state_r == ST_START) && !dram_r && !ata_s1_r && !ata_s2_r;
    endsequence
    // async ack caught by the falling edge of the second cycle, no other ack
    sequence s_async_c2;
        ata_s1_r && !ata_s2_r && sync_xfer_ack_n_in && xfer_error_ack_n_in;
    endsequence
    sequence s_last_ack;
        done_now && !err_now && !more;
    endsequence

    a_ts_one_cycle: assert property ($fell(xfer_start_n_out) |=> xfer_start_n_out) // see R2
        else $error("start strobe held longer than one cycle");
    a_write_data_c2: assert property (!xfer_start_n_out && (rw_out == RW_WRITE) |=> !data_oe_n_out) // see R4
        else $error("write data not driven in second cycle");
    a_data_wait_hold: assert property ((state_r == ST_WAIT) && !done_now && wr_r |=> $stable(data_out) && !data_oe_n_out) // see R13
        else $error("write data changed during wait state");
    a_release_last: assert property (s_last_ack and wr_r |=> data_oe_n_out && (state_r == ST_IDLE)) // see R8
        else $error("data drivers not released after final transfer");
    a_async_one_wait: assert property (s_async_c1 ##1 s_async_c2 |=> done_now) // see R14
        else $error("async ack not recognised at end of third cycle");
    a_dram_no_async: assert property ((state_r == ST_WAIT) && dram_r && sync_xfer_ack_n_in && xfer_error_ack_n_in |-> !done_now) // see R9
        else $error("async ack ended a DRAM transfer");
    a_error_ends: assert property ((state_r == ST_WAIT) && err_now |=> err_out && (state_r == ST_IDLE) && !done_out) // see R11
        else $error("error ack did not end the transfer");
    a_addr_step: assert property (done_now && !err_now && more |=> addr_out == $past(addr_r) + {23'h0, ebx_bytes(port_r)}) // see R7
        else $error("address not stepped by port size");
    a_byte_capture: assert property (done_now && !err_now && !wr_r && (port_r == SZ_BYTE)
        |=> rd_valid_out && (rd_data_out == {24'h000000, $past(data_in[31:24])})) // see R15
        else $error("byte read not captured from top lane");
    a_size_lines: assert property (!xfer_start_n_out |-> xfer_size_out == ebx_xfer_size(op_r, port_r) && xfer_size_out != SZ_LINE) // see R3
        else $error("size lines wrong during start");
    a_restart_next: assert property (done_now && !err_now && more && (!wr_r || drain_if.valid)
        |=> !xfer_start_n_out && (access_mode_line_out == (code_r ? ATM_CODE : ATM_DATA))) // see R1
        else $error("next split transfer did not restart");
endmodule : ebx_master

// [ebx_slave_model.sv]
// far-side slave model answering with sync, async, error or late sync acks
`timescale 1ns/1ps
module ebx_slave_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic xfer_start_n_in,
    input wire logic [31:0] data_in,
    input wire logic [1:0] mode_in,
    input wire logic [3:0] waits_in,
    input wire logic [31:0] rd_word_in,
    output logic sync_ack_n_out,
    output logic async_ack_n_out,
    output logic err_ack_n_out,
    output logic [31:0] data_out,
    output logic cap_out,
    output logic [31:0] cap_data_out
);
    int cnt;
    int hold;
    int c;
    logic act;
    // mode 0 sync, 1 async, 2 async with error, 3 async early then late sync
    always @(posedge clk_in) begin
        cap_out <= 1'b0;
        data_out <= ~data_out;
        if (srst_in) begin
            act <= 1'b0;
            cnt <= 0;
            hold <= 0;
            sync_ack_n_out <= 1'b1;
            async_ack_n_out <= 1'b1;
            err_ack_n_out <= 1'b1;
            data_out <= '0;
        end else if (!xfer_start_n_in || act) begin
            act <= 1'b1;
            data_out <= rd_word_in;
            c = xfer_start_n_in ? cnt : int'(waits_in);
            if (mode_in == 2'h3 && hold == 0) async_ack_n_out <= 1'b0;
            if (hold == 0 && c == 0) begin
                sync_ack_n_out <= !(mode_in == 2'h0 || mode_in == 2'h3);
                if (mode_in[0] != mode_in[1]) async_ack_n_out <= 1'b0;
                err_ack_n_out <= (mode_in != 2'h2);
                hold <= (mode_in == 2'h1) ? 2 : 1;
            end else if (hold == 1) begin
                sync_ack_n_out <= 1'b1;
                async_ack_n_out <= 1'b1;
                err_ack_n_out <= 1'b1;
                cap_out <= 1'b1;
                cap_data_out <= data_in;
                act <= 1'b0;
                hold <= 0;
            end else if (hold > 1) begin
                hold <= hold - 1;
            end
            if (c > 0) cnt <= c - 1;
        end
    end
endmodule : ebx_slave_model

// [tb.sv]
// self-checking bench for the external bus master with a slave model
`timescale 1ns/1ps
module tb;
    import ebx_pkg::*;
    logic clk_in = 0, srst_in = 1, rq_v = 0, rq_w = 0, rq_b = 0, rq_d = 0, rq_s = 0, rq_c = 0, wv = 0;
    logic [27:0] rq_a = '0, nxt_a, addr;
    logic [1:0] rq_o = '0, rq_p = '0, rq_t = '0, md = '0, tt, sz;
    logic [31:0] wd = '0, rdw = '0, bus_m, bus_s, bus_w, rd_data, cap_d;
    logic [3:0] wt = '0;
    logic tie = 0, ata_pin;
    logic rq_r, wr_r, rd_v, done, err, rw, mode_l, st_n, oe_n, ta_n, ata_n, tea_n, cap, prev_st;
    int miscompares, comparisons, cyc, xf;
    logic [31:0] exp_q[$];

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    ebx_master dut (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(rq_v), .req_ready_out(rq_r), .req_addr_in(rq_a),
        .req_write_in(rq_w), .req_op_size_in(rq_o), .req_port_size_in(rq_p), .req_burst_en_in(rq_b), .req_dram_in(rq_d),
        .req_xfer_type_in(rq_t), .req_super_in(rq_s), .req_code_in(rq_c), .wr_valid_in(wv), .wr_ready_out(wr_r),
        .wr_data_in(wd), .rd_valid_out(rd_v), .rd_data_out(rd_data), .done_out(done), .err_out(err), .addr_out(addr),
        .rw_out(rw), .xfer_type_out(tt), .xfer_size_out(sz), .access_mode_line_out(mode_l), .xfer_start_n_out(st_n),
        .data_out(bus_m), .data_oe_n_out(oe_n), .data_in(bus_s), .sync_xfer_ack_n_in(ta_n),
        .async_xfer_ack_n_in(ata_pin), .xfer_error_ack_n_in(tea_n));

    // a released data bus shows the inverse of the master's value
    assign bus_w = oe_n ? ~bus_m : bus_m;
    // tie holds the async ack low from before the strobe, as a grounded ack would
    assign ata_pin = ata_n && !tie;
    ebx_slave_model slave (.clk_in(clk_in), .srst_in(srst_in), .xfer_start_n_in(st_n), .data_in(bus_w), .mode_in(md),
        .waits_in(wt), .rd_word_in(rdw), .sync_ack_n_out(ta_n), .async_ack_n_out(ata_n), .err_ack_n_out(tea_n),
        .data_out(bus_s), .cap_out(cap), .cap_data_out(cap_d));

    function automatic int nb(input logic [1:0] s);
        return (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : (s == 2'h0) ? 4 : 16;
    endfunction : nb

    function automatic logic [31:0] lane(input logic [31:0] w, input logic [1:0] p);
        return (p == 2'h1) ? {24'h0, w[31:24]} : (p == 2'h2) ? {16'h0, w[31:16]} : w;
    endfunction : lane

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // bus monitor: strobe-cycle attributes, address stepping, captured data
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
        if (!srst_in && prev_st) check(mode_l, rq_s);
        prev_st <= !st_n && !srst_in;
        if (!srst_in && !st_n) begin
            check(addr, nxt_a);
            check({tt, sz, rw}, {rq_t, (nb(rq_o) > nb(rq_p)) ? rq_p : rq_o, !rq_w});
            check(mode_l, rq_c);
            nxt_a <= nxt_a + 28'(nb(rq_p));
            xf++;
        end
        if (cap && rq_w) check(lane(cap_d, rq_p), lane(exp_q.pop_front(), rq_p));
    end

    task automatic fill(input int k);
        logic [31:0] x;
        for (int i = 0; i < k; i++) begin
            x = $urandom;
            wv <= 1'b1;
            wd <= x;
            do @(posedge clk_in); while (!wr_r);
            exp_q.push_back(x);
        end
        wv <= 1'b0;
        @(posedge clk_in);
    endtask : fill

    task automatic op(input logic w, input logic [1:0] o, p, m, input logic d, input logic [3:0] ws, input int lat);
        int n;
        logic [27:0] a;
        a = 28'($urandom) & 28'hffffff0;
        md <= m;
        wt <= ws;
        rdw <= $urandom;
        rq_v <= 1'b1;
        rq_w <= w;
        rq_o <= o;
        rq_p <= p;
        rq_d <= d;
        rq_a <= a;
        nxt_a <= a;
        rq_t <= 2'($urandom);
        rq_s <= 1'($urandom);
        rq_c <= 1'($urandom);
        rq_b <= 1'($urandom);
        xf = 0;
        do @(posedge clk_in); while (!rq_r);
        rq_v <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (!done && !err);
        if (lat > 0) check(n, lat);
        check(err, m == 2'h2);
        check(xf, (m == 2'h2) ? 1 : (nb(o) > nb(p)) ? nb(o) / nb(p) : 1);
        if (w) check(oe_n, 1'b1);
        if (!w && m != 2'h2) check(rd_v, 1'b1);
        if (!w && m != 2'h2) check(rd_data, lane(rdw, p));
    endtask : op

    initial begin
        void'($urandom(32326));
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        fill(32);
        check(wr_r, 1'b0);
        op(1, SZ_LINE, SZ_BYTE, 2'h0, 0, 4'h1, 0);
        op(1, SZ_LINE, SZ_BYTE, 2'h1, 0, 4'h0, 0);
        check(wr_r, 1'b1);
        fill(2);
        op(1, SZ_LONG, SZ_WORD, 2'h0, 0, 4'h2, 0);
        fill(1);
        op(1, SZ_LONG, SZ_LONG, 2'h0, 0, 4'h0, 3);
        fill(1);
        op(1, SZ_BYTE, SZ_LONG, 2'h1, 0, 4'h0, 4);
        fill(1);
        fork
            op(1, SZ_LONG, SZ_BYTE, 2'h0, 0, 4'h0, 0);
            begin
                repeat (8) @(posedge clk_in);
                fill(3);
            end
        join
        op(0, SZ_BYTE, SZ_BYTE, 2'h1, 0, 4'h0, 4);
        op(0, SZ_WORD, SZ_LONG, 2'h2, 0, 4'h0, 3);
        repeat (4) @(posedge clk_in);
        op(0, SZ_LONG, SZ_LONG, 2'h3, 1, 4'h3, 6);
        tie <= 1'b1;
        op(0, SZ_LONG, SZ_LONG, 2'h0, 0, 4'h2, 3);
        repeat (4) @(posedge clk_in);
        tie <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < 8; i++) op(0, 2'($urandom), 2'($urandom % 3), 2'h0, 0, 4'($urandom % 4), 0);
        check(exp_q.size(), 0);
        report_and_stop();
    end
endmodule : tb
